// ===== rtl/dioc_pkg.sv
// Constants and types for the double-data-rate pin cell register block
package dioc_pkg;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam int         ADDR_W   = 4;
    localparam int         DATA_W   = 32;
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] INV_OFF  = 4'h4;
    localparam logic [3:0] STAT_OFF = 4'h8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***************************************************************
    // Field layouts
    // ***************************************************************
    typedef struct packed {
        logic clk_inv;
        logic side_bank;
        logic pwr_high;
        logic oe_low;
        logic align_fall;
        logic oe_ddr;
        logic out_ddr;
        logic in_ddr;
    } dioc_ctrl_type;

    typedef struct packed {
        logic dqs;
        logic aclr;
        logic sclr;
        logic ce_out;
        logic ce_in;
        logic oe;
        logic out_b;
        logic out_a;
        logic pin;
    } dioc_inv_type;

    localparam logic [7:0] CTRL_RST = 8'h07;
    localparam logic [8:0] INV_RST  = 9'h000;

    // Data and enable from internal logic toward the pin
    typedef struct packed {
        logic oe;
        logic b;
        logic a;
    } dioc_out_type;

    // Captured bit pair toward internal logic
    typedef struct packed {
        logic b;
        logic a;
    } dioc_in_type;

endpackage : dioc_pkg

// ===== rtl/dioc_ddr_io_cell_registers.sv
// Double-data-rate pin cell with its AXI4-Lite configuration slave
`timescale 1ns/1ps
`default_nettype none

module dioc_ddr_io_cell_registers (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [dioc_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [dioc_pkg::DATA_W-1:0]  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [dioc_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [dioc_pkg::DATA_W-1:0]       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    input  wire dioc_pkg::dioc_out_type       user_out,
    input  wire logic                         ce_in,
    input  wire logic                         ce_out,
    input  wire logic                         sclr,
    input  wire logic                         aclr,
    input  wire logic                         pin_i,
    input  wire logic                         dqs_i,
    output logic                              pin_o,
    output logic                              pin_oe,
    output dioc_pkg::dioc_in_type             user_in
);

    // ***************************************************************
    // Helpers
    // ***************************************************************
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic mapped(
        input logic [dioc_pkg::ADDR_W-1:0] addr
    );
        return (addr == dioc_pkg::CTRL_OFF) ||
               (addr == dioc_pkg::INV_OFF)  ||
               (addr == dioc_pkg::STAT_OFF);
    endfunction : mapped

    // ***************************************************************
    // Configuration registers
    // ***************************************************************
    dioc_pkg::dioc_ctrl_type ctrl_ff;
    dioc_pkg::dioc_inv_type  inv_ff;

    logic                        aw_hold_ff;
    logic                        w_hold_ff;
    logic [dioc_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0]                 wdata_ff;
    logic [3:0]                  wstrb_ff;
    logic                        bvalid_ff;
    logic [1:0]                  bresp_ff;
    logic                        rvalid_ff;
    logic [1:0]                  rresp_ff;
    logic [31:0]                 rdata_ff;

    logic                        aw_go;
    logic                        w_go;
    logic                        do_write;
    logic [dioc_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0]                 wr_data;
    logic [3:0]                  wr_strb;
    logic [31:0]                 status;

    assign awready  = !aw_hold_ff && !bvalid_ff;
    assign wready   = !w_hold_ff && !bvalid_ff;
    assign aw_go    = awvalid && awready;
    assign w_go     = wvalid && wready;
    assign do_write = (aw_hold_ff || aw_go) && (w_hold_ff || w_go);
    assign wr_addr  = aw_hold_ff ? awaddr_ff : awaddr;
    assign wr_data  = w_hold_ff ? wdata_ff : wdata;
    assign wr_strb  = w_hold_ff ? wstrb_ff : wstrb;

    assign bvalid   = bvalid_ff;
    assign bresp    = bresp_ff;
    assign arready  = !rvalid_ff;
    assign rvalid   = rvalid_ff;
    assign rresp    = rresp_ff;
    assign rdata    = rdata_ff;

    // Address and data may arrive in either order; each is parked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end else if (do_write) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
        end else begin
            if (aw_go) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= awaddr;
            end
            if (w_go) begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= dioc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= mapped(wr_addr) ? dioc_pkg::RESP_OKAY
                                         : dioc_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= dioc_pkg::CTRL_RST;
            inv_ff  <= dioc_pkg::INV_RST;
        end else if (do_write) begin
            if (wr_addr == dioc_pkg::CTRL_OFF) begin
                ctrl_ff <= 8'(merge({24'h000000, ctrl_ff},
                                    wr_data, wr_strb));
            end
            if (wr_addr == dioc_pkg::INV_OFF) begin
                inv_ff <= 9'(merge({23'h000000, inv_ff},
                                   wr_data, wr_strb));
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= dioc_pkg::RESP_OKAY;
            rdata_ff  <= '0;
        end else if (arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= mapped(araddr) ? dioc_pkg::RESP_OKAY
                                        : dioc_pkg::RESP_SLVERR;
            unique case (araddr)
                dioc_pkg::CTRL_OFF: rdata_ff <= {24'h000000, ctrl_ff};
                dioc_pkg::INV_OFF:  rdata_ff <= {23'h000000, inv_ff};
                dioc_pkg::STAT_OFF: rdata_ff <= status;
                default:            rdata_ff <= 32'h00000000;
            endcase
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ***************************************************************
    // Cell boundary: optional inversion of every input
    // ***************************************************************
    logic pin_v;
    logic dqs_v;
    logic ce_in_v;
    logic ce_out_v;
    logic sclr_v;
    logic clr_async;
    logic pwr;
    logic phase_hi;
    logic cell_sclr;
    logic cap_en;

    assign pin_v     = pin_i ^ inv_ff.pin;
    assign dqs_v     = dqs_i ^ inv_ff.dqs;
    assign ce_in_v   = ce_in ^ inv_ff.ce_in;
    assign ce_out_v  = ce_out ^ inv_ff.ce_out;
    assign sclr_v    = sclr ^ inv_ff.sclr;
    // Reset path through a config XOR: change inversion only while idle
    assign clr_async = aclr ^ inv_ff.aclr;
    // Clock inversion swaps the roles of the two phases
    assign phase_hi  = aclk ^ ctrl_ff.clk_inv;
    assign pwr       = ctrl_ff.pwr_high;
    assign cell_sclr = sclr_v || !aresetn;
    // Strobe only qualifies capture outside side-bank mode
    assign cap_en    = ce_in_v && (ctrl_ff.side_bank || dqs_v);

    // ***************************************************************
    // Cell storage
    // ***************************************************************
    // Each flop holds value XOR power-up level, so the shared
    // asynchronous clear loads a constant and still yields the
    // programmed level. Toggling pwr_high flips all held values.
    logic cap_r_ff;
    logic cap_f_ff;
    logic hold_lat;
    logic out_a_ff;
    logic out_b_ff;
    logic oe_r_ff;
    logic oe_f_ff;

    always_ff @(posedge aclk or posedge clr_async) begin
        if (clr_async) begin
            cap_r_ff <= 1'b0;
        end else if (cell_sclr) begin
            cap_r_ff <= 1'b0;
        end else if (cap_en) begin
            cap_r_ff <= pin_v ^ pwr;
        end
    end

    always_ff @(negedge aclk or posedge clr_async) begin
        if (clr_async) begin
            cap_f_ff <= 1'b0;
        end else if (cell_sclr) begin
            cap_f_ff <= 1'b0;
        end else if (cap_en && ctrl_ff.in_ddr) begin
            cap_f_ff <= pin_v ^ pwr;
        end
    end

    // Open in the high phase, carries the other-edge bit forward
    always_latch begin
        if (clr_async) begin
            hold_lat <= 1'b0;
        end else if (phase_hi) begin
            hold_lat <= ctrl_ff.clk_inv ? cap_r_ff : cap_f_ff;
        end
    end

    // Output and enable share clock and clock enable
    always_ff @(posedge aclk or posedge clr_async) begin
        if (clr_async) begin
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b0;
        end else if (cell_sclr) begin
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b0;
        end else if (ce_out_v) begin
            out_a_ff <= user_out.a ^ inv_ff.out_a ^ pwr;
            out_b_ff <= user_out.b ^ inv_ff.out_b ^ pwr;
        end
    end

    always_ff @(posedge aclk or posedge clr_async) begin
        if (clr_async) begin
            oe_r_ff <= 1'b0;
        end else if (cell_sclr) begin
            oe_r_ff <= 1'b0;
        end else if (ce_out_v) begin
            oe_r_ff <= user_out.oe ^ inv_ff.oe ^ pwr;
        end
    end

    always_ff @(negedge aclk or posedge clr_async) begin
        if (clr_async) begin
            oe_f_ff <= 1'b0;
        end else if (cell_sclr) begin
            oe_f_ff <= 1'b0;
        end else if (ce_out_v) begin
            oe_f_ff <= oe_r_ff;
        end
    end

    // ***************************************************************
    // Pin side
    // ***************************************************************
    logic out_a_v;
    logic out_b_v;
    logic oe_eff;

    assign out_a_v = out_a_ff ^ pwr;
    assign out_b_v = out_b_ff ^ pwr;

    // Clock is used as data here; that is the point of the cell
    always_comb begin
        if (ctrl_ff.out_ddr) begin
            pin_o = phase_hi ? out_a_v : out_b_v;
        end else begin
            pin_o = out_a_v;
        end
    end

    // With oe_ddr set, enable rises only once the falling-edge copy agrees; otherwise it follows the rising copy
    assign oe_eff = ctrl_ff.oe_ddr ? ((oe_r_ff ^ pwr) && (oe_f_ff ^ pwr))
                                   : (oe_r_ff ^ pwr);
    assign pin_oe = oe_eff ^ ctrl_ff.oe_low;

    // ***************************************************************
    // Internal side: realigned input pair
    // ***************************************************************
    logic p_raw;
    logic n_raw;

    assign p_raw = ctrl_ff.clk_inv ? cap_f_ff : cap_r_ff;
    assign n_raw = ctrl_ff.clk_inv ? cap_r_ff : cap_f_ff;

    // Falling alignment is only stable from falling to next rising edge
    always_comb begin
        if (!ctrl_ff.in_ddr) begin
            user_in.a = p_raw ^ pwr;
            user_in.b = p_raw ^ pwr;
        end else if (ctrl_ff.align_fall) begin
            user_in.a = p_raw ^ pwr;
            user_in.b = n_raw ^ pwr;
        end else begin
            user_in.a = hold_lat ^ pwr;
            user_in.b = p_raw ^ pwr;
        end
    end

    // Six status bits, one of them the latch, visible to software
    assign status = {26'h0000000, oe_eff, out_b_v, out_a_v,
                     hold_lat ^ pwr, user_in.b, user_in.a};

endmodule : dioc_ddr_io_cell_registers

`default_nettype wire

// ===== dv/dioc_mem_model.sv
// Memory-side model driving the shared data pin during reads
`timescale 1ns/1ps
`default_nettype none

module dioc_mem_model (
    input  wire logic aclk,
    input  wire logic rd,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_i,
    output logic      dqs_i
);
    logic [7:0] lfsr_ff;

    initial lfsr_ff = 8'h5A;

    // New bit each half period; a released wire never shows a steady level
    always @(posedge aclk or negedge aclk) begin
        lfsr_ff <= {lfsr_ff[6:0],
                    lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end

    assign pin_i = pin_oe ? pin_o : lfsr_ff[0];
    assign dqs_i = rd;
endmodule : dioc_mem_model

`default_nettype wire

// ===== dv/dioc_chk.sv
// Port assertions for the double-data-rate pin cell
`timescale 1ns/1ps
`default_nettype none

module dioc_chk (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   wvalid,
    input wire logic                   wready,
    input wire dioc_pkg::dioc_out_type user_out,
    input wire logic                   ce_in,
    input wire logic                   ce_out,
    input wire logic                   sclr,
    input wire logic                   aclr,
    input wire logic                   pin_i,
    input wire logic                   dqs_i,
    input wire logic                   pin_o,
    input wire logic                   pin_oe,
    input wire dioc_pkg::dioc_in_type  user_in
);
    // ****************************************
    // Expected cell state
    // ****************************************
    logic       dflt_ff, oa_ff, ob_ff, oe_ff, fq_ff, ia_ff, ib_ff;
    logic       oef_ff;
    logic [1:0] arm_ff;
    logic       ok, cap;

    // Only the reset configuration is modelled; any write turns checks off
    assign ok  = dflt_ff && (arm_ff == 2'h3) && !aclr && !sclr;
    assign cap = ce_in && dqs_i;

    always_ff @(posedge aclk) begin
        if (!aresetn) dflt_ff <= 1'b1;
        else if (wvalid && wready) dflt_ff <= 1'b0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || sclr || aclr) arm_ff <= 2'h0;
        else if (arm_ff != 2'h3) arm_ff <= arm_ff + 2'h1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || sclr || aclr) {oe_ff, ob_ff, oa_ff} <= 3'h0;
        else if (ce_out) {oe_ff, ob_ff, oa_ff} <= user_out;
    end
    // Falling enable copy shares the output clock enable
    always_ff @(negedge aclk) begin
        if (!aresetn || sclr || aclr) oef_ff <= 1'b0;
        else if (ce_out) oef_ff <= oe_ff;
    end
    always_ff @(negedge aclk) begin
        if (cap) fq_ff <= pin_i;
    end
    always_ff @(posedge aclk) begin
        if (cap) {ib_ff, ia_ff} <= {pin_i, fq_ff};
    end

    // ****************************************
    // Properties
    // ****************************************
    property p_out_hi;
        @(negedge aclk) disable iff (!aresetn) ok |-> pin_o == oa_ff;
    endproperty
    a_out_hi: assert property (p_out_hi)
        else $error("pin not first bit in high half");
    property p_out_lo;
        @(posedge aclk) disable iff (!aresetn) ok |-> pin_o == ob_ff;
    endproperty
    a_out_lo: assert property (p_out_lo)
        else $error("pin not second bit in low half");
    property p_oe_hi;
        @(negedge aclk) disable iff (!aresetn)
            ok |-> pin_oe == (oe_ff && oef_ff);
    endproperty
    a_oe_hi: assert property (p_oe_hi)
        else $error("enable not held off until falling edge");
    property p_oe_lo;
        @(posedge aclk) disable iff (!aresetn)
            ok |-> pin_oe == (oe_ff && oef_ff);
    endproperty
    a_oe_lo: assert property (p_oe_lo)
        else $error("enable wrong in low half");
    property p_in_pair;
        @(posedge aclk) disable iff (!aresetn)
            ok && cap && $past(cap) |-> user_in == {ib_ff, ia_ff};
    endproperty
    a_in_pair: assert property (p_in_pair)
        else $error("captured pair misaligned");
    property p_sclr;
        @(posedge aclk) disable iff (!aresetn || !dflt_ff || aclr)
            sclr |=> !pin_oe && !pin_o;
    endproperty
    a_sclr: assert property (p_sclr)
        else $error("synchronous clear had no effect");
    property p_aclr;
        @(negedge aclk) disable iff (!aresetn || !dflt_ff)
            aclr |-> !pin_o && !pin_oe;
    endproperty
    a_aclr: assert property (p_aclr)
        else $error("asynchronous clear had no effect");
    property p_ce_hold;
        @(posedge aclk) disable iff (!aresetn)
            ok && !ce_out |=> ($stable(pin_o) || aclr);
    endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("output changed with clock enable low");
endmodule : dioc_chk

bind dioc_ddr_io_cell_registers dioc_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .wvalid(wvalid), .wready(wready),
    .user_out(user_out), .ce_in(ce_in), .ce_out(ce_out), .sclr(sclr),
    .aclr(aclr), .pin_i(pin_i), .dqs_i(dqs_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .user_in(user_in)
);

`default_nettype wire

// ===== dv/tb_ddr_io_cell_registers.sv
// Self-checking bench for the pin cell with random output data
`timescale 1ns/1ps
`default_nettype none

module tb_ddr_io_cell_registers;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ce_in = 1'b1;
    logic        ce_out = 1'b1, sclr = 1'b0, aclr = 1'b0, rd = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe;
    logic        pin_i, dqs_i, r, f, ea, eb, eo, eo_p;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0, tests_run = 0, seed = 41980, cyc = 0;
    dioc_pkg::dioc_out_type user_out = 3'h0;
    dioc_pkg::dioc_in_type  user_in;

    dioc_ddr_io_cell_registers dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .user_out(user_out), .ce_in(ce_in), .ce_out(ce_out), .sclr(sclr),
        .aclr(aclr), .pin_i(pin_i), .dqs_i(dqs_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .user_in(user_in)
    );
    dioc_mem_model u_mem (
        .aclk(aclk), .rd(rd), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_i(pin_i), .dqs_i(dqs_i)
    );

    always #12.5 aclk = ~aclk;

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task summarize;
        $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(dioc_pkg::RESP_OKAY), 32'(bresp));
    endtask : wr

    task rd_reg(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask : rd_reg

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {ea, eb, eo, eo_p} = 4'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(dioc_pkg::CTRL_OFF, 32'(dioc_pkg::CTRL_RST), dioc_pkg::RESP_OKAY);
        rd_reg(dioc_pkg::INV_OFF, 32'(dioc_pkg::INV_RST), dioc_pkg::RESP_OKAY);
        rd_reg(4'hC, 32'h0, dioc_pkg::RESP_SLVERR);
        // Random data and enable, some cycles with the clock enable low
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (ce_out === 1'b1) {eo, eb, ea} = user_out;
            user_out <= 3'($random(seed));
            ce_out   <= ($random(seed) % 4 != 0);
            #6;
            chk("pin_o high", 32'(ea), 32'(pin_o));
            chk("pin_oe high", 32'(eo & eo_p), 32'(pin_oe));
            @(negedge aclk);
            // Falling enable copy loads only with the output clock enable
            if (ce_out === 1'b1) eo_p = eo;
            #6;
            chk("pin_o low", 32'(eb), 32'(pin_o));
            chk("pin_oe low", 32'(eo & eo_p), 32'(pin_oe));
        end
        user_out <= 3'h0;
        ce_out   <= 1'b1;
        repeat (2) @(posedge aclk);
        rd <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 16; i++) begin
            @(negedge aclk);
            f = pin_i;
            @(posedge aclk);
            r = pin_i;
            #6;
            chk("user_in rise", 32'({r, f}), 32'(user_in));
        end
        // Clears with all output and enable registers loaded high
        rd       <= 1'b0;
        user_out <= 3'h7;
        repeat (3) @(posedge aclk);
        sclr <= 1'b1;
        @(posedge aclk);
        sclr <= 1'b0;
        #6;
        chk("pin_o sclr", 32'h0, 32'(pin_o));
        chk("pin_oe sclr", 32'h0, 32'(pin_oe));
        repeat (2) @(posedge aclk);
        aclr <= 1'b1;
        #6;
        chk("pin_o aclr", 32'h0, 32'(pin_o));
        chk("pin_oe aclr", 32'h0, 32'(pin_oe));
        @(posedge aclk);
        aclr     <= 1'b0;
        user_out <= 3'h0;
        wr(dioc_pkg::CTRL_OFF, 32'h17);
        repeat (2) @(posedge aclk);
        #6;
        chk("pin_oe low pol", 32'h1, 32'(pin_oe));
        wr(dioc_pkg::CTRL_OFF, 32'h0F);
        rd <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            r = pin_i;
            @(negedge aclk);
            f = pin_i;
            #6;
            chk("user_in fall", 32'({f, r}), 32'(user_in));
        end
        wr(dioc_pkg::CTRL_OFF, 32'h47);
        rd <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) wr(dioc_pkg::INV_OFF, 32'h1);
            @(posedge aclk);
            r = pin_i;
            #6;
            chk("user_in.b", 32'(r ^ (i >= 3)), 32'(user_in.b));
        end
        wr(dioc_pkg::INV_OFF, 32'h0);
        wr(dioc_pkg::CTRL_OFF, 32'h27);
        rd_reg(dioc_pkg::CTRL_OFF, 32'h27, dioc_pkg::RESP_OKAY);
        @(posedge aclk);
        aclr <= 1'b1;
        #6;
        chk("pin_o preset", 32'h1, 32'(pin_o));
        @(posedge aclk);
        aclr    <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(dioc_pkg::CTRL_OFF, 32'(dioc_pkg::CTRL_RST), dioc_pkg::RESP_OKAY);
        summarize();
    end
endmodule : tb_ddr_io_cell_registers

`default_nettype wire
